// File: rtl/timer_b_defs.svh
`ifndef TIMER_B_DEFS_SVH
`define TIMER_B_DEFS_SVH

// Register offsets on the 4-bit byte address.
`define OFS_CONTROL_A 4'h0
`define OFS_MODE_OUTPUT_CONTROL 4'h1
`define OFS_EVENT_INPUT_CONTROL 4'h4
`define OFS_INTERRUPT_ENABLE 4'h5
`define OFS_INTERRUPT_FLAG 4'h6
`define OFS_RUN_STATUS 4'h7
`define OFS_COUNT_LOW 4'hA
`define OFS_COUNT_HIGH 4'hB
`define OFS_COMPARE_LOW 4'hC
`define OFS_COMPARE_HIGH 4'hD

// Field positions.
`define BIT_STANDBY_KEEP_RUNNING 6
`define BIT_RESTART_WITH_COMPANION 4
`define POS_COUNT_CLOCK_SELECT 1
`define BIT_ENABLE 0
`define BIT_OUTPUT_RISE_ON_EVENT 6
`define BIT_OUTPUT_INITIAL_LEVEL 5
`define BIT_OUTPUT_GATE 4
`define POS_COUNTER_MODE 0
`define BIT_FILTER 6
`define BIT_EDGE 4
`define BIT_EVENT_INPUT_ENABLE 0
`define BIT_CC_EVENT_FLAG 0

// Writable bits of each register; the rest read as zero.
`define MASK_CONTROL_A 8'h57
`define MASK_MODE_OUTPUT_CONTROL 8'h77
`define MASK_EVENT_INPUT_CONTROL 8'h51

// Reset values.
`define RST_REG8 8'h00
`define RST_REG16 16'h0000

// Number of equal samples the noise filter needs.
`define FILTER_SAMPLES 4

`endif

// File: rtl/timer_b_pkg.sv
package timer_b_pkg;

	typedef enum logic [2:0] {
		MODE_PERIODIC = 3'b000,
		MODE_TIMEOUT = 3'b001,
		MODE_CAPTURE = 3'b010,
		MODE_FREQ = 3'b011,
		MODE_PULSE_WIDTH = 3'b100,
		MODE_FREQ_PW = 3'b101,
		MODE_SINGLE_SHOT = 3'b110,
		MODE_PWM8 = 3'b111
	} counter_mode_t;

	typedef enum logic [1:0] {
		CLKSRC_PERIPHERAL = 2'b00,
		CLKSRC_HALF = 2'b01,
		CLKSRC_COMPANION = 2'b10,
		CLKSRC_RESERVED = 2'b11
	} clock_src_t;

	// Phases of the combined frequency and pulse-width measurement.
	typedef enum logic [1:0] {
		FPW_IDLE = 2'b00,
		FPW_HIGH = 2'b01,
		FPW_LOW = 2'b10
	} fpw_phase_t;

	typedef struct packed {
		logic wr;
		logic rd;
		logic [3:0] addr;
		logic [7:0] wdata;
	} bus_req_t;

	typedef struct packed {
		logic [7:0] control_a;
		logic [7:0] mode_output_control;
		logic [7:0] event_input_control;
		logic interrupt_enable;
		logic cc_event_flag;
		logic [15:0] count;
		logic [15:0] compare_value;
		logic run;
		logic shot_out;
		logic pwm_out;
		logic half_phase;
		fpw_phase_t fpw_phase;
		logic [3:0] filter_hist;
		logic event_level;
		logic event_prev;
		logic [7:0] rdata;
		logic irq;
		logic event_strobe;
		logic wave;
	} state_t;

endpackage : timer_b_pkg

// File: rtl/timer_b_unit.sv
// Functional notes
// - Standby keeps running if bit set, not companion
// - Companion restart restarts our count
// - Clock select: peripheral, half, companion, reserved
// - Enable bit switches timer on
// - Single-shot output rises on start or event
// - Initial level bit sets output level, except single-shot, PWM
// - Output gate zero forces output low
// - Three-bit field selects eight counter modes
// - Filter bit inserts noise filter
// - Timeout mode: edges start and stop counter
// - Capture mode: selected edge captures, flags
// - Frequency mode: capture, clear, restart, flag
// - Pulse-width: one edge clears, other captures
// - Combined mode: clear, capture, stop sequence
// - Events ignored in periodic, PWM; single-shot start
// - Events act only with input enable
// - Interrupt enable lets flag request interrupt
// - Flag cleared by write one, capture read
// - Request held while flag and enable set
// - Filter needs four equal samples
//
// Added by the designer: the strobed register port.
`include "timer_b_defs.svh"
`timescale 1ns/10ps
`default_nettype none

module timer_b_unit (
	input wire logic i_clock,
	input wire logic i_rst,
	input wire logic i_clk_en,
	input wire logic [3:0] i_addr,
	input wire logic [7:0] i_wdata,
	input wire logic i_wr,
	input wire logic i_rd,
	input wire logic i_event,
	input wire logic i_companion_tick,
	input wire logic i_companion_restart,
	input wire logic i_standby,
	output logic [7:0] o_rdata,
	output logic o_irq,
	output logic o_wave,
	output logic o_event_strobe,
	output logic o_running
);

	timer_b_pkg::state_t q;
	timer_b_pkg::state_t d;
	timer_b_pkg::bus_req_t req;
	timer_b_pkg::counter_mode_t mode;
	timer_b_pkg::clock_src_t clk_src;

	// Picks the acting edge: rising when the edge bit is clear, else falling.
	function automatic logic pick_edge(input logic rise, input logic fall,
		input logic edge_sel);
		pick_edge = edge_sel ? fall : rise;
	endfunction : pick_edge

	assign req = '{wr: i_wr, rd: i_rd, addr: i_addr, wdata: i_wdata};
	assign mode = timer_b_pkg::counter_mode_t'(q.mode_output_control[2:0]);
	assign clk_src = timer_b_pkg::clock_src_t'(
		q.control_a[`POS_COUNT_CLOCK_SELECT +: 2]);

	logic enable;
	logic edge_sel;
	logic tick;
	logic rise;
	logic fall;
	logic act_edge;
	logic other_edge;
	logic ev_ok;
	logic capture;
	logic clear_cnt;
	logic set_flag;
	logic clr_flag;
	logic at_top;
	logic cap_read;

	assign enable = q.control_a[`BIT_ENABLE];
	assign edge_sel = q.event_input_control[`BIT_EDGE];
	assign rise = q.event_level & ~q.event_prev;
	assign fall = ~q.event_level & q.event_prev;
	assign ev_ok = enable & q.event_input_control[`BIT_EVENT_INPUT_ENABLE];
	assign act_edge = ev_ok & pick_edge(rise, fall, edge_sel);
	assign other_edge = ev_ok & pick_edge(rise, fall, ~edge_sel);
	assign at_top = (q.count == q.compare_value);
	assign cap_read = req.rd & (req.addr == `OFS_COMPARE_LOW)
		& (mode inside {timer_b_pkg::MODE_CAPTURE, timer_b_pkg::MODE_FREQ,
		timer_b_pkg::MODE_PULSE_WIDTH, timer_b_pkg::MODE_FREQ_PW});

	always_comb begin
		d = q;
		capture = 1'b0;
		clear_cnt = 1'b0;
		set_flag = 1'b0;
		tick = 1'b0;
		d.event_strobe = 1'b0;
		d.rdata = `RST_REG8;

		d.filter_hist = {q.filter_hist[2:0], i_event};
		if (q.event_input_control[`BIT_FILTER]) begin
			if (&d.filter_hist) begin
				d.event_level = 1'b1;
			end else if (~|d.filter_hist) begin
				d.event_level = 1'b0;
			end
		end else begin
			d.event_level = i_event;
		end
		d.event_prev = q.event_level;

		d.half_phase = enable ? ~q.half_phase : 1'b0;
		case (clk_src)
			timer_b_pkg::CLKSRC_PERIPHERAL: tick = 1'b1;
			timer_b_pkg::CLKSRC_HALF: tick = q.half_phase;
			timer_b_pkg::CLKSRC_COMPANION: tick = i_companion_tick;
			default: tick = 1'b0;
		endcase
		if (i_standby && !q.control_a[`BIT_STANDBY_KEEP_RUNNING]
			&& clk_src != timer_b_pkg::CLKSRC_COMPANION) begin
			tick = 1'b0;
		end
		tick = tick & enable;

		case (mode)
			timer_b_pkg::MODE_PERIODIC: begin
				d.run = enable;
			end
			timer_b_pkg::MODE_TIMEOUT: begin
				if (act_edge) begin
					d.run = 1'b1;
				end else if (other_edge) begin
					d.run = 1'b0;
				end
			end
			timer_b_pkg::MODE_CAPTURE: begin
				d.run = enable;
				capture = act_edge;
				set_flag = act_edge;
			end
			timer_b_pkg::MODE_FREQ: begin
				d.run = enable;
				capture = act_edge;
				clear_cnt = act_edge;
				set_flag = act_edge;
			end
			timer_b_pkg::MODE_PULSE_WIDTH: begin
				d.run = enable;
				clear_cnt = act_edge;
				capture = other_edge;
				set_flag = other_edge;
			end
			timer_b_pkg::MODE_FREQ_PW: begin
				case (q.fpw_phase)
					timer_b_pkg::FPW_IDLE: begin
						if (act_edge) begin
							clear_cnt = 1'b1;
							d.run = 1'b1;
							d.fpw_phase = timer_b_pkg::FPW_HIGH;
						end
					end
					timer_b_pkg::FPW_HIGH: begin
						if (other_edge) begin
							capture = 1'b1;
							d.fpw_phase = timer_b_pkg::FPW_LOW;
						end
					end
					timer_b_pkg::FPW_LOW: begin
						if (act_edge) begin
							d.run = 1'b0;
							set_flag = 1'b1;
							d.fpw_phase = timer_b_pkg::FPW_IDLE;
						end
					end
					default: d.fpw_phase = timer_b_pkg::FPW_IDLE;
				endcase
			end
			timer_b_pkg::MODE_SINGLE_SHOT: begin
				if (ev_ok && !q.run && (rise || (edge_sel && fall))) begin
					d.run = 1'b1;
					clear_cnt = 1'b1;
					if (q.mode_output_control[`BIT_OUTPUT_RISE_ON_EVENT]) begin
						d.shot_out = 1'b1;
					end
				end
			end
			timer_b_pkg::MODE_PWM8: begin
				d.run = enable;
			end
			default: d.run = 1'b0;
		endcase

		if (!enable) begin
			d.run = 1'b0;
			d.shot_out = 1'b0;
			d.fpw_phase = timer_b_pkg::FPW_IDLE;
		end
		if (mode != timer_b_pkg::MODE_FREQ_PW) begin
			d.fpw_phase = timer_b_pkg::FPW_IDLE;
		end

		if (capture) begin
			d.compare_value = q.count;
		end

		// Counting uses the state before this cycle's start request.
		if (clear_cnt) begin
			d.count = `RST_REG16;
		end else if (q.run && tick) begin
			case (mode)
				timer_b_pkg::MODE_PERIODIC, timer_b_pkg::MODE_TIMEOUT: begin
					d.count = at_top ? `RST_REG16 : q.count + 16'h0001;
					set_flag = at_top;
				end
				timer_b_pkg::MODE_SINGLE_SHOT: begin
					if (!q.mode_output_control[`BIT_OUTPUT_RISE_ON_EVENT]) begin
						d.shot_out = 1'b1;
					end
					if (at_top) begin
						d.count = `RST_REG16;
						d.run = 1'b0;
						d.shot_out = 1'b0;
						set_flag = 1'b1;
					end else begin
						d.count = q.count + 16'h0001;
					end
				end
				timer_b_pkg::MODE_PWM8: begin
					if (q.count[7:0] == q.compare_value[7:0]) begin
						d.count = `RST_REG16;
						set_flag = 1'b1;
					end else begin
						d.count = {8'h00, q.count[7:0] + 8'h01};
					end
				end
				default: d.count = q.count + 16'h0001;
			endcase
		end

		if (q.control_a[`BIT_RESTART_WITH_COMPANION] && i_companion_restart
			&& enable) begin
			d.count = `RST_REG16;
		end

		// High while the low compare byte is nonzero and the count is below the high-time byte.
		d.pwm_out = (q.compare_value[7:0] != 8'h00)
			&& (d.count[7:0] < q.compare_value[15:8]);

		// Software writes take priority over internal count updates.
		clr_flag = cap_read;
		if (req.wr) begin
			case (req.addr)
				`OFS_CONTROL_A: d.control_a = req.wdata & `MASK_CONTROL_A;
				`OFS_MODE_OUTPUT_CONTROL:
					d.mode_output_control = req.wdata & `MASK_MODE_OUTPUT_CONTROL;
				`OFS_EVENT_INPUT_CONTROL:
					d.event_input_control = req.wdata & `MASK_EVENT_INPUT_CONTROL;
				`OFS_INTERRUPT_ENABLE: d.interrupt_enable = req.wdata[0];
				`OFS_INTERRUPT_FLAG: clr_flag = clr_flag | req.wdata[0];
				`OFS_COUNT_LOW: d.count[7:0] = req.wdata;
				`OFS_COUNT_HIGH: d.count[15:8] = req.wdata;
				`OFS_COMPARE_LOW: d.compare_value[7:0] = req.wdata;
				`OFS_COMPARE_HIGH: d.compare_value[15:8] = req.wdata;
				default: ;
			endcase
		end

		// clear, but a same-cycle set wins
		d.cc_event_flag = (q.cc_event_flag & ~clr_flag) | set_flag;
		d.event_strobe = set_flag;
		d.irq = d.cc_event_flag & d.interrupt_enable;

		if (!d.mode_output_control[`BIT_OUTPUT_GATE]) begin
			d.wave = 1'b0;
		end else if (mode == timer_b_pkg::MODE_SINGLE_SHOT) begin
			d.wave = d.shot_out;
		end else if (mode == timer_b_pkg::MODE_PWM8) begin
			d.wave = d.pwm_out;
		end else begin
			d.wave = d.mode_output_control[`BIT_OUTPUT_INITIAL_LEVEL];
		end

		if (req.rd) begin
			case (req.addr)
				`OFS_CONTROL_A: d.rdata = q.control_a;
				`OFS_MODE_OUTPUT_CONTROL: d.rdata = q.mode_output_control;
				`OFS_EVENT_INPUT_CONTROL: d.rdata = q.event_input_control;
				`OFS_INTERRUPT_ENABLE: d.rdata = {7'h00, q.interrupt_enable};
				`OFS_INTERRUPT_FLAG: d.rdata = {7'h00, q.cc_event_flag};
				`OFS_RUN_STATUS: d.rdata = {7'h00, q.run};
				`OFS_COUNT_LOW: d.rdata = q.count[7:0];
				`OFS_COUNT_HIGH: d.rdata = q.count[15:8];
				`OFS_COMPARE_LOW: d.rdata = q.compare_value[7:0];
				`OFS_COMPARE_HIGH: d.rdata = q.compare_value[15:8];
				default: d.rdata = `RST_REG8;
			endcase
		end
	end

	always_ff @(posedge i_clock) begin
		if (i_rst) begin
			q <= '0;
		end else if (i_clk_en) begin
			q <= d;
		end
	end

	assign o_rdata = q.rdata;
	assign o_irq = q.irq;
	assign o_wave = q.wave;
	assign o_event_strobe = q.event_strobe;
	assign o_running = q.run;

	default clocking cb @(posedge i_clock);
	endclocking
	default disable iff (i_rst);

	sequence s_flag_write_one;
		i_clk_en && i_wr && i_addr == `OFS_INTERRUPT_FLAG && i_wdata[0]
			&& !set_flag;
	endsequence

	sequence s_capture_edge;
		i_clk_en && mode == timer_b_pkg::MODE_CAPTURE && act_edge && !i_wr;
	endsequence

	a_irq_follows_flag: assert property (
		o_irq == (q.cc_event_flag && q.interrupt_enable))
		else $error("interrupt request does not follow flag and enable");

	a_flag_w1c: assert property (
		s_flag_write_one |=> !q.cc_event_flag)
		else $error("flag not cleared by write of one");

	a_capture_loads: assert property (
		s_capture_edge |=> q.compare_value == $past(q.count) && q.cc_event_flag)
		else $error("capture edge did not load counter and set flag");

	a_gate_forces_low: assert property (
		!q.mode_output_control[`BIT_OUTPUT_GATE] |-> !o_wave)
		else $error("output not low with gate off");

	a_disabled_stopped: assert property (
		i_clk_en && !enable |=> !o_running)
		else $error("counter running while disabled");

	a_no_event_without_en: assert property (
		!ev_ok |-> !act_edge && !other_edge)
		else $error("event acted with input disabled");

	a_reserved_clock: assert property (
		i_clk_en && clk_src == timer_b_pkg::CLKSRC_RESERVED && !i_wr
			&& !clear_cnt && !(i_companion_restart
			&& q.control_a[`BIT_RESTART_WITH_COMPANION])
		|=> q.count == $past(q.count))
		else $error("count moved under reserved clock select");

	a_filter_delay: assert property (
		q.event_input_control[`BIT_FILTER] && i_clk_en
			&& d.event_level != q.event_level
		|-> d.filter_hist == {4{d.event_level}})
		else $error("filter passed a change without four equal samples");

	a_idle_level: assert property (
		q.mode_output_control[`BIT_OUTPUT_GATE] && mode == timer_b_pkg::MODE_PERIODIC
		|-> o_wave == q.mode_output_control[`BIT_OUTPUT_INITIAL_LEVEL])
		else $error("output does not show initial level");

	a_shot_output_rise_on_event: assert property (
		i_clk_en && mode == timer_b_pkg::MODE_SINGLE_SHOT && !q.run && ev_ok && rise
			&& q.mode_output_control[`BIT_OUTPUT_RISE_ON_EVENT]
			&& q.mode_output_control[`BIT_OUTPUT_GATE] && !i_wr
		|=> o_wave && o_running)
		else $error("single-shot output did not rise on event");

endmodule : timer_b_unit

`default_nettype wire

// File: bench/event_net.sv
`timescale 1ns/10ps
`default_nettype none

// Event routing stage: re-times the requested level onto the channel.
// The channel is a level on the shared clock, so it holds between changes.
module event_net (
	input wire logic i_clock,
	input wire logic i_rst,
	input wire logic i_lvl,
	output logic o_event
);
	always_ff @(posedge i_clock) begin
		if (i_rst) begin
			o_event <= 1'b0;
		end else begin
			o_event <= i_lvl;
		end
	end
endmodule : event_net

`default_nettype wire

// File: bench/timer_b_unit_tb_top.sv
`timescale 1ns/10ps
`default_nettype none

module timer_b_unit_tb_top;
	typedef struct packed {
		logic [3:0] a;
		logic [7:0] d;
		logic [7:0] e;
	} row_t;
	typedef struct packed {
		logic [7:0] c;
		logic s;
		logic [7:0] d;
	} sb_t;
	localparam row_t rows [7] = '{'{4'h0, 8'h52, 8'h52}, '{4'h1, 8'hFF, 8'h77},
		'{4'h4, 8'hFF, 8'h51}, '{4'h5, 8'hFF, 8'h01}, '{4'h2, 8'hFF, 8'h00},
		'{4'h7, 8'hFF, 8'h00}, '{4'h6, 8'h00, 8'h00}};
	localparam sb_t sb_rows [6] = '{'{8'h00, 1'b0, 8'h00}, '{8'h01, 1'b0, 8'h02},
		'{8'h03, 1'b0, 8'h01}, '{8'h01, 1'b1, 8'h00}, '{8'h41, 1'b1, 8'h02},
		'{8'h05, 1'b0, 8'h00}};
	logic i_clock = 1'b0;
	logic i_rst = 1'b1;
	logic [3:0] addr = 4'h0;
	logic [7:0] wdata = 8'h00;
	logic wr = 1'b0;
	logic rd = 1'b0;
	logic ev_lvl = 1'b0;
	logic tick = 1'b0;
	logic restart = 1'b0;
	logic standby = 1'b0;
	logic ev;
	logic [7:0] rdata;
	logic irq;
	logic wave;
	logic strobe;
	logic running;
	logic [7:0] v;
	logic [7:0] w;
	int n_mismatch = 0;
	int cmp_count = 0;
	int n_strobe = 0;
	int k;

	event_net net (.i_clock(i_clock), .i_rst(i_rst), .i_lvl(ev_lvl), .o_event(ev));

	timer_b_unit uut (.i_clock(i_clock), .i_rst(i_rst), .i_clk_en(1'b1), .i_addr(addr),
		.i_wdata(wdata), .i_wr(wr), .i_rd(rd), .i_event(ev), .i_companion_tick(tick),
		.i_companion_restart(restart), .i_standby(standby), .o_rdata(rdata), .o_irq(irq),
		.o_wave(wave), .o_event_strobe(strobe), .o_running(running));

	always #50 i_clock = ~i_clock;

	always @(posedge i_clock) begin
		if (strobe === 1'b1) begin
			n_strobe++;
		end
	end

	task automatic chk(input string nm, input logic [7:0] got, input logic [7:0] exp);
		cmp_count++;
		if (got !== exp) begin
			n_mismatch++;
			$display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
		end
	endtask : chk

	task automatic cyc(input int n);
		repeat (n) @(posedge i_clock);
	endtask : cyc

	task automatic wreg(input logic [3:0] a, input logic [7:0] d);
		@(posedge i_clock);
		addr <= a;
		wdata <= d;
		wr <= 1'b1;
		@(posedge i_clock);
		wr <= 1'b0;
	endtask : wreg

	// Read data are valid only in the cycle after the strobe, so sample just past that edge.
	task automatic rreg(input logic [3:0] a, output logic [7:0] d);
		@(posedge i_clock);
		addr <= a;
		rd <= 1'b1;
		@(posedge i_clock);
		rd <= 1'b0;
		#1 d = rdata;
	endtask : rreg

	task automatic ev_to(input logic l);
		@(posedge i_clock);
		ev_lvl <= l;
	endtask : ev_to

	task automatic cfg(input logic [7:0] c, input logic [7:0] m, input logic [7:0] e);
		wreg(4'h1, m);
		wreg(4'h4, e);
		wreg(4'h0, c);
	endtask : cfg

	task automatic period(input int p, output logic [7:0] c);
		repeat (3) begin
			ev_to(1'b1);
			cyc(4);
			ev_to(1'b0);
			cyc(p - 6);
		end
		rreg(4'hC, c);
	endtask : period

	// A leading opposite edge fixes the level, so the measured pulse always starts cleanly.
	task automatic pw(input logic l, input int h, output logic [7:0] c);
		ev_to(!l);
		cyc(3);
		ev_to(l);
		cyc(h);
		ev_to(!l);
		cyc(4);
		rreg(4'hC, c);
	endtask : pw

	task automatic flag_is(input logic f);
		rreg(4'h6, v);
		chk("flag", v, {7'h00, f});
	endtask : flag_is

	task automatic conclude();
		$display("comparisons %0d mismatches %0d", cmp_count, n_mismatch);
		if (n_mismatch == 0 && cmp_count > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask : conclude

	initial begin
		repeat (30000) @(posedge i_clock);
		n_mismatch++;
		conclude();
	end

	initial begin
		cyc(16);
		i_rst <= 1'b0;
		foreach (rows[i]) begin
			rreg(rows[i].a, v);
			chk("reset value", v, 8'h00);
			wreg(rows[i].a, rows[i].d);
			rreg(rows[i].a, v);
			chk("readback", v, rows[i].e);
		end
		cfg(8'h00, 8'h00, 8'h00);
		wreg(4'h5, 8'h00);
		wreg(4'hC, 8'hFF);
		wreg(4'hD, 8'hFF);
		foreach (sb_rows[i]) begin
			@(posedge i_clock);
			standby <= sb_rows[i].s;
			wreg(4'h0, sb_rows[i].c);
			rreg(4'hA, v);
			rreg(4'hA, w);
			chk("count step", 8'(w - v), sb_rows[i].d);
		end
		standby <= 1'b0;
		// Stopping first makes the first start check depend on the start edge alone.
		wreg(4'h0, 8'h00);
		for (k = 0; k < 2; k++) begin
			cfg(8'h01, 8'h01, k[0] ? 8'h11 : 8'h01);
			ev_to(1'b1);
			cyc(4);
			rreg(4'h7, v);
			chk("timeout run", v, {7'h00, !k[0]});
			ev_to(1'b0);
			cyc(4);
			rreg(4'h7, v);
			chk("timeout run", v, {7'h00, k[0]});
		end
		cfg(8'h01, 8'h00, 8'h01);
		ev_to(1'b1);
		cyc(4);
		ev_to(1'b0);
		cyc(4);
		flag_is(1'b0);
		wreg(4'h5, 8'h01);
		for (k = 0; k < 2; k++) begin
			cfg(8'h01, 8'h02, k[0] ? 8'h11 : 8'h01);
			w = 8'(n_strobe);
			ev_to(1'b1);
			cyc(4);
			flag_is(!k[0]);
			ev_to(1'b0);
			cyc(4);
			flag_is(1'b1);
			chk("strobes", 8'(n_strobe) - w, 8'h01);
			chk("irq set", {7'h00, irq}, 8'h01);
			if (k == 0) begin
				wreg(4'h6, 8'h01);
			end else begin
				rreg(4'hC, v);
			end
			flag_is(1'b0);
			chk("irq clear", {7'h00, irq}, 8'h00);
		end
		wreg(4'h5, 8'h00);
		cfg(8'h01, 8'h02, 8'h01);
		ev_to(1'b1);
		cyc(4);
		chk("irq masked", {7'h00, irq}, 8'h00);
		wreg(4'h6, 8'h01);
		ev_to(1'b0);
		wreg(4'h4, 8'h00);
		ev_to(1'b1);
		cyc(4);
		flag_is(1'b0);
		ev_to(1'b0);
		cyc(4);
		wreg(4'h4, 8'h41);
		ev_to(1'b1);
		cyc(1);
		ev_to(1'b0);
		cyc(8);
		flag_is(1'b0);
		ev_to(1'b1);
		cyc(6);
		flag_is(1'b1);
		wreg(4'h6, 8'h01);
		ev_to(1'b0);
		wreg(4'h4, 8'h01);
		ev_to(1'b1);
		cyc(1);
		ev_to(1'b0);
		cyc(4);
		flag_is(1'b1);
		for (k = 0; k < 2; k++) begin
			cfg(k[0] ? 8'h03 : 8'h01, 8'h03, 8'h01);
			period(20, v);
			period(30, w);
			chk("period diff", 8'(w - v), k[0] ? 8'h05 : 8'h0A);
		end
		for (k = 0; k < 2; k++) begin
			cfg(8'h01, 8'h04, k[0] ? 8'h11 : 8'h01);
			pw(!k[0], 10, v);
			pw(!k[0], 20, w);
			chk("width diff", 8'(w - v), 8'h0A);
		end
		cfg(8'h01, 8'h05, 8'h01);
		wreg(4'h6, 8'h01);
		pw(1'b1, 10, v);
		chk("combined width", v, 8'h0A);
		flag_is(1'b0);
		ev_to(1'b1);
		cyc(4);
		flag_is(1'b1);
		ev_to(1'b0);
		for (k = 0; k < 3; k++) begin
			cfg(8'h00, k == 0 ? 8'h30 : (k == 1 ? 8'h20 : 8'h10), 8'h00);
			cyc(2);
			chk("wave level", {7'h00, wave}, {7'h00, k == 0});
		end
		wreg(4'hC, 8'h40);
		wreg(4'hD, 8'h00);
		cfg(8'h00, 8'h16, 8'h00);
		ev_to(1'b1);
		cyc(2);
		cfg(8'h01, 8'h16, 8'h01);
		ev_to(1'b0);
		cyc(4);
		chk("shot idle", {7'h00, running}, 8'h00);
		ev_to(1'b1);
		// The output rises at the first count edge, so look one edge after it.
		cyc(5);
		chk("shot start", {6'h00, running, wave}, 8'h03);
		cyc(80);
		chk("shot end", {6'h00, running, wave}, 8'h00);
		wreg(4'h4, 8'h11);
		ev_to(1'b0);
		cyc(4);
		chk("either edge", {7'h00, running}, 8'h01);
		cyc(80);
		for (k = 0; k < 2; k++) begin
			cfg(8'h05, k[0] ? 8'h56 : 8'h16, 8'h11);
			ev_to(!ev_lvl);
			cyc(4);
			chk("output_rise_on_event rise", {7'h00, wave}, {7'h00, k[0]});
			tick <= 1'b1;
			@(posedge i_clock);
			tick <= 1'b0;
			cyc(3);
			chk("tick rise", {7'h00, wave}, 8'h01);
			wreg(4'h0, 8'h00);
		end
		// A preset count shows whether the companion restart really cleared it.
		wreg(4'hA, 8'h20);
		cfg(8'h11, 8'h00, 8'h00);
		restart <= 1'b1;
		@(posedge i_clock);
		restart <= 1'b0;
		rreg(4'hA, v);
		chk("companion restart", v, 8'h01);
		@(posedge i_clock);
		i_rst <= 1'b1;
		@(posedge i_clock);
		i_rst <= 1'b0;
		foreach (rows[i]) begin
			rreg(rows[i].a, v);
			chk("second reset", v, 8'h00);
		end
		conclude();
	end
endmodule : timer_b_unit_tb_top

`default_nettype wire
